//--- design/esmec_top.sv
`timescale 1ns/1ps
`default_nettype none
module esmec_top #(
  parameter int LONG_CYCLES_P  = esmec_pkg::LONG_CYCLES,
  parameter int SHORT_CYCLES_P = esmec_pkg::SHORT_CYCLES
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [9:0]               s_axi_awaddr,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [9:0]               s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  input  wire esmec_pkg::esmec_line_t   line,
  input  wire esmec_pkg::esmec_evt_t    evt,
  input  wire esmec_pkg::esmec_sync_t   sync,
  input  wire logic [7:0]               alarmIn,
  output logic                          irq
);
  import esmec_pkg::*;

  // ****************************************
  // register state
  // ****************************************
  logic [7:0]         control_q;
  logic [7:0]         control_d;
  logic [7:0]         alarmMask_q;
  logic [7:0]         alarmMask_d;
  logic [7:0]         eventMask_q;
  logic [7:0]         eventMask_d;
  logic [7:0]         alarmStatus_q;
  logic [7:0]         alarmStatus_d;
  logic [7:0]         eventStatus_q;
  logic [7:0]         eventStatus_d;
  logic [VIOL_W-1:0]  violSnap_q;
  logic [CRC_W-1:0]   crcSnap_q;
  logic               irq_q;

  // control fields
  wire countIntervalSelect = control_q[CTL_INTERVAL_BIT];
  wire violationTypeSelect = control_q[CTL_VTYPE_BIT];
  wire rxHdb3Enable        = control_q[CTL_HDB3_BIT];

  // ****************************************
  // line code violation detection
  // ****************************************
  logic       lastPol_q;
  logic       lastViolPol_q;
  logic [1:0] zeroRun_q;

  // a slot with both rails high is not a mark; it counts as a zero
  wire mark     = line.valid & (line.pos ^ line.neg);
  wire markPol  = line.pos;
  wire bpv      = mark & (markPol == lastPol_q);
  // substitution violation: at least two zeros before it, polarity alternates
  wire hdb3Code = bpv & (zeroRun_q == 2'h2)
                & (markPol != lastViolPol_q);
  wire codeViol = bpv & (markPol == lastViolPol_q);
  wire bpvEvt   = bpv & ~(rxHdb3Enable & hdb3Code);
  // no sync term here: violations count in every state
  wire violEvt  = violationTypeSelect ? codeViol : bpvEvt;

  // polarity history and zero run since last mark
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastPol_q     <= 1'b0;
      lastViolPol_q <= 1'b0;
      zeroRun_q     <= 2'h0;
    end else if (line.valid) begin
      lastPol_q     <= mark ? markPol : lastPol_q;
      lastViolPol_q <= bpv ? markPol : lastViolPol_q;
      zeroRun_q     <= mark ? 2'h0
                     : (zeroRun_q == 2'h2) ? zeroRun_q
                     : zeroRun_q + 2'h1;
    end
  end

  // ****************************************
  // interval timer
  // ****************************************
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] timer_d;

  wire                tick = (timer_q == '0);
  wire [TIMER_W-1:0]  reload = countIntervalSelect
                             ? TIMER_W'(SHORT_CYCLES_P - 1)
                             : TIMER_W'(LONG_CYCLES_P - 1);

  // a change of interval select takes effect at the next boundary
  assign timer_d = tick ? reload : timer_q - 1'b1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= TIMER_W'(LONG_CYCLES_P - 1);
    end else begin
      timer_q <= timer_d;
    end
  end

  // ****************************************
  // error counters
  // ****************************************
  logic [VIOL_W-1:0] violCount;
  logic [CRC_W-1:0]  crcCount;

  // crc errors only count with fas and crc4 alignment held
  wire crcInc = sync.crcError & ~sync.rxSyncLossFlag
              & ~sync.crc4SyncLoss;

  esmec_counter #(
    .WIDTH    (VIOL_W),
    .SATURATE (1'b1)
  ) u_violCounter (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inc     (violEvt),
    .restart (tick),
    .count   (violCount)
  );

  // at most 1000 errors per second, so no saturation needed
  esmec_counter #(
    .WIDTH    (CRC_W),
    .SATURATE (1'b0)
  ) u_crcCounter (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inc     (crcInc),
    .restart (tick),
    .count   (crcCount)
  );

  // snapshots; unread data is overwritten at the next boundary
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      violSnap_q <= '0;
      crcSnap_q  <= '0;
    end else if (tick) begin
      violSnap_q <= violCount;
      crcSnap_q  <= crcCount;
    end
  end

  // ****************************************
  // bus slave: write path
  // ****************************************
  logic       awReady_q;
  logic       wReady_q;
  logic       bValid_q;
  logic [1:0] bResp_q;
  logic [7:0] awIdx_q;
  logic [7:0] wData_q;
  logic       wLane0_q;

  function automatic logic isMapped(input logic [7:0] idx);
    isMapped = (idx == IDX_VIOL_UPPER)   || (idx == IDX_VIOL_LOWER)
            || (idx == IDX_CRC_UPPER)    || (idx == IDX_CRC_LOWER)
            || (idx == IDX_ALARM_STATUS) || (idx == IDX_EVENT_STATUS)
            || (idx == IDX_ALARM_MASK)   || (idx == IDX_EVENT_MASK)
            || (idx == IDX_CONTROL);
  endfunction

  wire awFire  = s_axi_awvalid & awReady_q;
  wire wFire   = s_axi_wvalid & wReady_q;
  wire bFire   = bValid_q & s_axi_bready;
  // both halves held and not yet answered
  wire doWrite = ~awReady_q & ~wReady_q & ~bValid_q;
  wire wrLow   = doWrite & wLane0_q;

  // writable registers; read-only targets ignore the data
  assign alarmMask_d = (wrLow && awIdx_q == IDX_ALARM_MASK)
                     ? wData_q : alarmMask_q;
  assign eventMask_d = (wrLow && awIdx_q == IDX_EVENT_MASK)
                     ? wData_q : eventMask_q;
  assign control_d   = (wrLow && awIdx_q == IDX_CONTROL)
                     ? wData_q : control_q;

  // address and data are taken in either order
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      awIdx_q   <= 8'h00;
      wData_q   <= 8'h00;
      wLane0_q  <= 1'b0;
    end else begin
      awReady_q <= bFire ? 1'b1 : (awFire ? 1'b0 : awReady_q);
      wReady_q  <= bFire ? 1'b1 : (wFire ? 1'b0 : wReady_q);
      awIdx_q   <= awFire ? s_axi_awaddr[9:2] : awIdx_q;
      wData_q   <= wFire ? s_axi_wdata[7:0] : wData_q;
      wLane0_q  <= wFire ? s_axi_wstrb[0] : wLane0_q;
    end
  end

  // write answer, one cycle after both halves are held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q  <= isMapped(awIdx_q) ? RESP_OKAY : RESP_DECERR;
    end else if (bFire) begin
      bValid_q <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control_q   <= CONTROL_RESET;
      alarmMask_q <= MASK_RESET;
      eventMask_q <= MASK_RESET;
    end else begin
      control_q   <= control_d;
      alarmMask_q <= alarmMask_d;
      eventMask_q <= eventMask_d;
    end
  end

  // ****************************************
  // bus slave: read path
  // ****************************************
  logic        arReady_q;
  logic        rValid_q;
  logic [7:0]  rData_q;
  logic [1:0]  rResp_q;

  wire       arFire = s_axi_arvalid & arReady_q;
  wire       rFire  = rValid_q & s_axi_rready;
  wire [7:0] arIdx  = s_axi_araddr[9:2];
  // fas error bits share the crc upper byte; they read as zero here
  wire [7:0] crcUpper = {6'h00, crcSnap_q[9:8]};
  wire [7:0] rdByte =
      (arIdx == IDX_VIOL_UPPER)   ? violSnap_q[15:8] :
      (arIdx == IDX_VIOL_LOWER)   ? violSnap_q[7:0]  :
      (arIdx == IDX_CRC_UPPER)    ? crcUpper         :
      (arIdx == IDX_CRC_LOWER)    ? crcSnap_q[7:0]   :
      (arIdx == IDX_ALARM_STATUS) ? alarmStatus_q    :
      (arIdx == IDX_EVENT_STATUS) ? eventStatus_q    :
      (arIdx == IDX_ALARM_MASK)   ? alarmMask_q      :
      (arIdx == IDX_EVENT_MASK)   ? eventMask_q      :
      (arIdx == IDX_CONTROL)      ? control_q        : 8'h00;

  // status reads clear what they return
  wire rdAlarmClr = arFire & (arIdx == IDX_ALARM_STATUS);
  wire rdEventClr = arFire & (arIdx == IDX_EVENT_STATUS);

  // read answer in the cycle after the address is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 8'h00;
      rResp_q   <= RESP_OKAY;
    end else if (arFire) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b1;
      rData_q   <= rdByte;
      rResp_q   <= isMapped(arIdx) ? RESP_OKAY : RESP_DECERR;
    end else if (rFire) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
    end
  end

  // ****************************************
  // status and interrupt
  // ****************************************
  wire [7:0] eventSet = {
    evt.rxCasMultiframeFlag,
    evt.rxAlignFrameFlag,
    evt.txMultiframeFlag,
    tick,
    evt.txAlignFrameFlag,
    evt.txClockLossFlag,
    evt.rxCrc4MultiframeFlag,
    evt.txSlipFlag
  };

  // set wins over a clearing read in the same cycle
  assign eventStatus_d = (eventStatus_q & ~{8{rdEventClr}}) | eventSet;
  assign alarmStatus_d = (alarmStatus_q & ~{8{rdAlarmClr}}) | alarmIn;

  wire alarmIrq = |(alarmStatus_q & alarmMask_q);
  wire eventIrq = |(eventStatus_q & eventMask_q);

  // irq lags status by one cycle to come from a flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarmStatus_q <= STATUS_RESET;
      eventStatus_q <= STATUS_RESET;
      irq_q         <= 1'b0;
    end else begin
      alarmStatus_q <= alarmStatus_d;
      eventStatus_q <= eventStatus_d;
      irq_q         <= alarmIrq | eventIrq;
    end
  end

  // outputs, all from flops
  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = {24'h000000, rData_q};
  assign s_axi_rresp   = rResp_q;
  assign irq           = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_reload_interval: assert property (
    tick |=> timer_q == ($past(countIntervalSelect)
                         ? TIMER_W'(SHORT_CYCLES_P - 1)
                         : TIMER_W'(LONG_CYCLES_P - 1)))
    else $error("timer reload wrong");

  chk_snapshot_copy: assert property (
    tick |=> violSnap_q == $past(violCount)
          && crcSnap_q == $past(crcCount))
    else $error("snapshot not taken");

  chk_timer_flag: assert property (
    tick |=> eventStatus_q[EV_TIMER])
    else $error("timer flag missing");

  chk_viol_upper_read: assert property (
    arFire && arIdx == IDX_VIOL_UPPER
    |=> s_axi_rdata == {24'h000000, $past(violSnap_q[15:8])})
    else $error("violation upper byte wrong");

  chk_hdb3_skip: assert property (
    !violationTypeSelect && rxHdb3Enable && hdb3Code && !tick
    |=> violCount == $past(violCount))
    else $error("hdb3 codeword counted");

  chk_bpv_count: assert property (
    !violationTypeSelect && bpv && !hdb3Code && !tick
    && violCount != 16'hffff
    |=> violCount == $past(violCount) + 16'h0001)
    else $error("bipolar violation lost");

  chk_code_viol_only: assert property (
    violationTypeSelect && bpv && !codeViol && !tick
    |=> violCount == $past(violCount))
    else $error("plain bpv counted as code violation");

  chk_viol_in_loss: assert property (
    sync.rxSyncLossFlag && violEvt && !tick && violCount != 16'hffff
    |=> violCount == $past(violCount) + 16'h0001)
    else $error("violation dropped during sync loss");

  chk_viol_saturate: assert property (
    violCount == 16'hffff && !tick |=> violCount == 16'hffff)
    else $error("violation counter wrapped");

  chk_crc_wrap: assert property (
    crcCount == 10'h3ff && crcInc && !tick |=> crcCount == 10'h000)
    else $error("crc counter did not wrap");

  chk_crc_inhibit: assert property (
    (sync.rxSyncLossFlag || sync.crc4SyncLoss) && !tick
    |=> crcCount == $past(crcCount))
    else $error("crc counted without alignment");

  chk_crc_upper_read: assert property (
    arFire && arIdx == IDX_CRC_UPPER
    |=> s_axi_rdata == {30'h00000000, $past(crcSnap_q[9:8])})
    else $error("crc upper bits misplaced");

  chk_align_flag: assert property (
    evt.rxAlignFrameFlag |=> eventStatus_q[EV_ALIGN])
    else $error("align frame flag missing");

  chk_slip_flag: assert property (
    evt.txSlipFlag |=> eventStatus_q[EV_TX_SLIP])
    else $error("slip flag missing");

  chk_alarm_irq: assert property (
    |(alarmStatus_q & alarmMask_q) |=> irq)
    else $error("enabled alarm gave no irq");

  chk_event_irq: assert property (
    |(eventStatus_q & eventMask_q) |=> irq)
    else $error("enabled event gave no irq");

  chk_irq_release: assert property (
    !(alarmIrq || eventIrq) |=> !irq)
    else $error("irq without enabled status");

  cov_short_tick: cover property (tick && countIntervalSelect);
  cov_saturated:  cover property (violCount == 16'hffff && tick);
  cov_clear_read: cover property (rdEventClr && irq);
  cov_hdb3_skip:  cover property (rxHdb3Enable && hdb3Code);
endmodule // esmec_top
`default_nettype wire

//--- design/esmec_pkg.sv
`default_nettype none
// ****************************************
// shared constants and carriers
// ****************************************
package esmec_pkg;
  // timing: clock and count intervals
  localparam int CLK_PERIOD_NS     = 25;
  localparam int LONG_INTERVAL_MS  = 1000;
  localparam int SHORT_INTERVAL_US = 62500;
  localparam int LONG_CYCLES  = LONG_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SHORT_CYCLES = SHORT_INTERVAL_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W      = 26;
  localparam int VIOL_W       = 16;
  localparam int CRC_W        = 10;
  localparam int ADDR_W       = 10;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_VIOL_UPPER   = 8'h00;
  localparam logic [7:0] IDX_VIOL_LOWER   = 8'h01;
  localparam logic [7:0] IDX_CRC_UPPER    = 8'h02;
  localparam logic [7:0] IDX_CRC_LOWER    = 8'h03;
  localparam logic [7:0] IDX_ALARM_STATUS = 8'h06;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h07;
  localparam logic [7:0] IDX_ALARM_MASK   = 8'h16;
  localparam logic [7:0] IDX_EVENT_MASK   = 8'h17;
  localparam logic [7:0] IDX_CONTROL      = 8'h20;

  // control register fields
  localparam int CTL_INTERVAL_BIT = 7;
  localparam int CTL_VTYPE_BIT    = 6;
  localparam int CTL_HDB3_BIT     = 2;

  // event status bit positions
  localparam int EV_CAS_MF    = 7;
  localparam int EV_ALIGN     = 6;
  localparam int EV_TX_MF     = 5;
  localparam int EV_TIMER     = 4;
  localparam int EV_TX_ALIGN  = 3;
  localparam int EV_CLK_LOSS  = 2;
  localparam int EV_CRC4_MF   = 1;
  localparam int EV_TX_SLIP   = 0;

  // values after reset
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // one received bit slot: valid strobe and mark polarity rails
  typedef struct packed {
    logic valid;
    logic pos;
    logic neg;
  } esmec_line_t;

  // framer and transmitter event pulses
  typedef struct packed {
    logic rxCasMultiframeFlag;
    logic rxAlignFrameFlag;
    logic txMultiframeFlag;
    logic txAlignFrameFlag;
    logic txClockLossFlag;
    logic rxCrc4MultiframeFlag;
    logic txSlipFlag;
  } esmec_evt_t;

  // synchroniser state and crc checker result
  typedef struct packed {
    logic rxSyncLossFlag;
    logic crc4SyncLoss;
    logic crcError;
  } esmec_sync_t;
endpackage
`default_nettype wire

//--- design/esmec_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// interval event counter
// ****************************************
module esmec_counter #(
  parameter int WIDTH    = 16,
  parameter bit SATURATE = 1'b1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             inc,
  input  wire logic             restart,
  output logic [WIDTH-1:0]      count
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             atTop;

  // restart keeps an event of the same cycle for the new interval
  assign atTop   = SATURATE && (&count_q);
  assign count_d = restart ? {{(WIDTH-1){1'b0}}, inc}
                 : (inc && !atTop) ? count_q + 1'b1 : count_q;
  assign count   = count_q;

  // plain register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // esmec_counter
`default_nettype wire

//--- dv/esmec_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host bus master model
// ****************************************
module esmec_host (
  input  wire logic        mclk,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [9:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [9:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr} = 20'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
  end

  // one write; payload inverted once taken, so a late sampler sees junk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    output logic [1:0] resp);
    int n;
    @(posedge mclk);
    resp = 2'hx;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~s_axi_wdata;
      end
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // one read; a hang leaves unknown data for the caller to reject
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    int n;
    @(posedge mclk);
    d = 32'hx;
    resp = 2'hx;
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~s_axi_araddr;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // esmec_host
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import esmec_pkg::*;
  // short intervals keep the run brief; long still fits a full saturation
  localparam int LONG_P  = 66000;
  localparam int SHORT_P = 100;
  logic        mclk, rst_n, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  alarmIn;
  esmec_line_t line;
  esmec_evt_t  evt;
  esmec_sync_t sync;
  int          failures, totalChecks;
  int          cyc = 0;
  int          evPos [7] = '{EV_TX_SLIP, EV_CRC4_MF, EV_CLK_LOSS,
                             EV_TX_ALIGN, EV_TX_MF, EV_ALIGN, EV_CAS_MF};

  esmec_top #(.LONG_CYCLES_P(LONG_P), .SHORT_CYCLES_P(SHORT_P)) i_dut (
    .mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .line, .evt, .sync, .alarmIn, .irq);
  esmec_host i_host (
    .mclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);

  // ****************************************
  // clock, cycle count, watchdog
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    close_out();
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    i_host.rd(idx, d, r);
    chk(d, {24'h0, exp});
  endtask
  task automatic wrc(input logic [7:0] idx, input logic [7:0] v);
    logic [1:0] r;
    i_host.wr(idx, v, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  // waits on the timer interrupt, then clears it; stamp is the cycle seen
  task automatic waitTick(output int t);
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (2) @(posedge mclk);
    for (n = 0; n < 70000 && irq !== 1'b1; n++) @(posedge mclk);
    t = cyc;
    if (n == 70000) begin
      failures++;
      close_out();
    end
    i_host.rd(IDX_EVENT_STATUS, d, r);
    chk({31'h0, d[EV_TIMER]}, 32'h1);
  endtask
  // line slots, two bits each {pos,neg}, first slot in the low pair
  task automatic slots(input logic [9:0] v, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge mclk);
      line <= {1'b1, v[2*i+1], v[2*i]};
    end
    @(posedge mclk);
    line <= '0;
  endtask
  task automatic crcHit(input logic crcLoss);
    @(posedge mclk);
    sync <= {1'b0, crcLoss, 1'b1};
    @(posedge mclk);
    sync <= '0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int          t0, t1;
    logic [31:0] d;
    logic [1:0]  r;
    failures = 0;
    totalChecks = 0;
    rst_n = 1'b0;
    line = '0;
    evt = '0;
    sync = '0;
    alarmIn = 8'h00;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values, refusals, read-only place
    rdc(IDX_ALARM_MASK, MASK_RESET);
    rdc(IDX_EVENT_MASK, MASK_RESET);
    rdc(IDX_EVENT_STATUS, STATUS_RESET);
    i_host.rd(8'h30, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
    i_host.wr(8'h31, 8'h5a, r);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
    wrc(IDX_VIOL_LOWER, 8'h5a);
    rdc(IDX_VIOL_LOWER, 8'h00);
    wrc(IDX_CONTROL, 8'h80);
    wrc(IDX_EVENT_MASK, 8'h10);
    rdc(IDX_EVENT_MASK, 8'h10);
    // every slot a positive mark, sync lost: violations pile past full scale
    for (int i = 0; i < 65540; i++) begin
      @(posedge mclk);
      line <= 3'b110;
      sync <= {2'b10, (i % 1000 == 0)};
    end
    @(posedge mclk);
    line <= '0;
    sync <= '0;
    waitTick(t0);
    rdc(IDX_VIOL_UPPER, 8'hff);
    rdc(IDX_VIOL_LOWER, 8'hff);
    rdc(IDX_CRC_LOWER, 8'h00);
    waitTick(t1);
    chk(32'(t1 - t0), 32'(SHORT_P));
    // bipolar: - - - gives two; crc: three counted, one under crc4 loss
    slots(10'b0000010101, 3);
    repeat (3) crcHit(1'b0);
    crcHit(1'b1);
    waitTick(t0);
    rdc(IDX_VIOL_UPPER, 8'h00);
    rdc(IDX_VIOL_LOWER, 8'h02);
    rdc(IDX_CRC_UPPER, 8'h00);
    rdc(IDX_CRC_LOWER, 8'h03);
    // code violations: + + + - - holds one repeat of violation polarity
    wrc(IDX_CONTROL, 8'hc0);
    waitTick(t0);
    slots(10'b0101101010, 5);
    waitTick(t0);
    rdc(IDX_VIOL_LOWER, 8'h01);
    // hdb3 on: + 0 0 + is a substitution, the last + a real violation
    wrc(IDX_CONTROL, 8'h84);
    waitTick(t0);
    slots(10'b1010000010, 5);
    waitTick(t0);
    rdc(IDX_VIOL_LOWER, 8'h01);
    // a masked event leaves the interrupt low
    wrc(IDX_EVENT_MASK, 8'hee);
    @(posedge mclk);
    evt <= esmec_evt_t'(7'h01);
    @(posedge mclk);
    evt <= '0;
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_EVENT_STATUS, 8'h01);
    // each event: its own bit, its own mask bit, cleared by the read
    for (int k = 0; k < 7; k++) begin
      wrc(IDX_EVENT_MASK, 8'(1 << evPos[k]));
      @(posedge mclk);
      evt <= esmec_evt_t'(7'(1 << k));
      @(posedge mclk);
      evt <= '0;
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      i_host.rd(IDX_EVENT_STATUS, d, r);
      chk(d & 32'hef, 32'(1 << evPos[k]));
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
    end
    // alarm level gated by its mask bit
    @(posedge mclk);
    alarmIn <= 8'h08;
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wrc(IDX_ALARM_MASK, 8'h08);
    rdc(IDX_ALARM_MASK, 8'h08);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    alarmIn <= 8'h00;
    rdc(IDX_ALARM_STATUS, 8'h08);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    close_out();
  end
endmodule // tb
`default_nettype wire
